// ---- rtl/lmc_pkg.sv ----
// lmc_pkg: constants shared by the lost motion compensation stage
// assumes a 200 MHz control clock and a plain register port
package lmc_pkg;
   // clock and time base
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TICK_TIME_PS = 100_000_000; // 0.1 ms time base
   localparam int TICK_CYCLES = TICK_TIME_PS / CLK_PERIOD_PS;
   // register offsets
   localparam logic [7:0] OFS_FUNC_SELECT = 8'h00;
   localparam logic [7:0] OFS_AMT_FWD_TO_REV = 8'h04;
   localparam logic [7:0] OFS_AMT_REV_TO_FWD = 8'h08;
   localparam logic [7:0] OFS_FILTER_TC = 8'h0C;
   localparam logic [7:0] OFS_START_DELAY = 8'h10;
   localparam logic [7:0] OFS_DEAD_BAND = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   // function select fields
   localparam int BIT_ENABLE = 0;
   localparam int BIT_UNIT_KPULSE = 1;
   // reset values
   localparam logic [1:0] RST_FUNC_SELECT = 2'h0;
   localparam logic [15:0] RST_AMOUNT = 16'h0000;
   localparam logic [15:0] RST_FILTER_TC = 16'h0000;
   localparam logic [15:0] RST_START_DELAY = 16'h0000;
   localparam logic [15:0] RST_DEAD_BAND = 16'h0000;
   // pulses per kpulse unit
   localparam logic [9:0] KPULSE_SCALE = 10'h03E8;
   // decay step shift of the high-pass filter
   localparam int HPF_SHIFT = 4;
   localparam logic [4:0] HPF_STEPS = 5'h10;
   // control modes
   typedef enum logic [1:0] {
      LMC_MODE_POSITION = 2'h0,
      LMC_MODE_POSITIONING = 2'h1,
      LMC_MODE_SPEED = 2'h2,
      LMC_MODE_TORQUE = 2'h3
   } lmc_mode_t;
   // compensation sequence, gray along idle-delay-apply
   typedef enum logic [1:0] {
      LMC_IDLE = 2'b00,
      LMC_DELAY = 2'b01,
      LMC_APPLY = 2'b11
   } lmc_state_t;
endpackage : lmc_pkg

// ---- rtl/lmc_lost_motion_comp.sv ----
// lmc_lost_motion_comp: adds a direction dependent torque step on reversal
// assumes droop and torque inputs come from logic on the same clock
// Behaviour
// (R01) Compensation acts only in position mode or positioning mode.
// (R02) Function select bit 0 at 0 keeps compensation off, at 1 turns it on.
// (R03) Function select bit 1 scales the dead band in pulses (0) or kpulses (1).
// (R04) Separate amounts serve forward-to-reverse and reverse-to-forward reversals.
// (R05) Every reversal of detected travel direction starts a compensation event.
// (R06) Each event starts only after the programmed delay from the reversal.
// (R07) The start delay is zero after reset.
// (R08) Droop fluctuation at or below the dead band counts as zero speed.
// (R09) A nonzero filter time constant makes the amount decay; zero holds it.
// (R10) The chosen amount is added to the torque, signed for the new direction.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module lmc_lost_motion_comp #(
   parameter int TICK_LEN = lmc_pkg::TICK_CYCLES
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   input wire logic [1:0] ctrlMode,
   input wire logic droopValid,
   input wire logic signed [15:0] droopDelta,
   input wire logic signed [15:0] torqueIn,
   output logic signed [15:0] torqueOut,
   output logic compActive
);
   initial
   begin
      if (TICK_LEN < 1 || TICK_LEN > 65535)
      begin
         $error("TICK_LEN out of range");
      end
   end

   logic [1:0] funcSelect;
   logic [15:0] amtFwdToRev;
   logic [15:0] amtRevToFwd;
   logic [15:0] filterTc;
   logic [15:0] startDelay;
   logic [15:0] deadBand;
   logic [1:0] next_funcSelect;
   logic [15:0] next_amtFwdToRev;
   logic [15:0] next_amtRevToFwd;
   logic [15:0] next_filterTc;
   logic [15:0] next_startDelay;
   logic [15:0] next_deadBand;
   logic [15:0] next_regRdata;

   lmc_pkg::lmc_state_t state;
   lmc_pkg::lmc_state_t next_state;
   logic dirKnown;
   logic dirFwd;
   logic next_dirKnown;
   logic next_dirFwd;
   logic [15:0] tickCnt;
   logic [15:0] next_tickCnt;
   logic [15:0] delayCnt;
   logic [15:0] next_delayCnt;
   logic [15:0] hpfAcc;
   logic [15:0] next_hpfAcc;
   logic signed [16:0] comp;
   logic signed [16:0] next_comp;
   logic signed [15:0] next_torqueOut;
   logic next_compActive;

   logic modeOk;
   logic enabled;
   logic tick;
   logic [16:0] absDelta;
   logic [25:0] threshold;
   logic moving;
   logic reversal;
   logic signed [17:0] sum;

   // load the amount for a reversal into the given direction
   function automatic logic signed [16:0] lmc_amount(input logic toFwd,
         input logic [15:0] fwdToRev, input logic [15:0] revToFwd);
      lmc_amount = toFwd ? $signed({1'b0, revToFwd}) : -$signed({1'b0, fwdToRev});
   endfunction : lmc_amount

   // (R01) mode gate
   assign modeOk = (ctrlMode == lmc_pkg::LMC_MODE_POSITION)
      || (ctrlMode == lmc_pkg::LMC_MODE_POSITIONING);
   // (R02) enable gate
   assign enabled = funcSelect[lmc_pkg::BIT_ENABLE] && modeOk;
   assign tick = (tickCnt == 16'(TICK_LEN - 1));

   // zero speed detection against the scaled dead band
   assign absDelta = droopDelta[15] ? 17'(-$signed({droopDelta[15], droopDelta}))
      : {1'b0, droopDelta};
   // (R03) dead band unit
   assign threshold = funcSelect[lmc_pkg::BIT_UNIT_KPULSE]
      ? 26'(deadBand * lmc_pkg::KPULSE_SCALE) : {10'h000, deadBand};
   // (R08) zero speed band
   assign moving = {9'h000, absDelta} > threshold;
   // (R05) reversal detect
   assign reversal = clkEn && droopValid && moving && dirKnown
      && (dirFwd == droopDelta[15]);

   // register writes and reads
   always_comb
   begin
      next_funcSelect = funcSelect;
      next_amtFwdToRev = amtFwdToRev;
      next_amtRevToFwd = amtRevToFwd;
      next_filterTc = filterTc;
      next_startDelay = startDelay;
      next_deadBand = deadBand;
      next_regRdata = 16'h0000;
      if (regWr)
      begin
         if (regAddr == lmc_pkg::OFS_FUNC_SELECT)
            next_funcSelect = regWdata[1:0];
         else if (regAddr == lmc_pkg::OFS_AMT_FWD_TO_REV)
            next_amtFwdToRev = regWdata;
         else if (regAddr == lmc_pkg::OFS_AMT_REV_TO_FWD)
            next_amtRevToFwd = regWdata;
         else if (regAddr == lmc_pkg::OFS_FILTER_TC)
            next_filterTc = regWdata;
         else if (regAddr == lmc_pkg::OFS_START_DELAY)
            next_startDelay = regWdata;
         else if (regAddr == lmc_pkg::OFS_DEAD_BAND)
            next_deadBand = regWdata;
      end
      if (regRd)
      begin
         if (regAddr == lmc_pkg::OFS_FUNC_SELECT)
            next_regRdata = {14'h0000, funcSelect};
         else if (regAddr == lmc_pkg::OFS_AMT_FWD_TO_REV)
            next_regRdata = amtFwdToRev;
         else if (regAddr == lmc_pkg::OFS_AMT_REV_TO_FWD)
            next_regRdata = amtRevToFwd;
         else if (regAddr == lmc_pkg::OFS_FILTER_TC)
            next_regRdata = filterTc;
         else if (regAddr == lmc_pkg::OFS_START_DELAY)
            next_regRdata = startDelay;
         else if (regAddr == lmc_pkg::OFS_DEAD_BAND)
            next_regRdata = deadBand;
         else if (regAddr == lmc_pkg::OFS_STATUS)
            next_regRdata = {11'h000, dirKnown, dirFwd, modeOk, state};
      end
   end

   // register file; the bus is served regardless of clock enable
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         funcSelect <= lmc_pkg::RST_FUNC_SELECT;
         amtFwdToRev <= lmc_pkg::RST_AMOUNT;
         amtRevToFwd <= lmc_pkg::RST_AMOUNT;
         filterTc <= lmc_pkg::RST_FILTER_TC;
         // (R07) delay starts at zero
         startDelay <= lmc_pkg::RST_START_DELAY;
         deadBand <= lmc_pkg::RST_DEAD_BAND;
         regRdata <= 16'h0000;
      end
      else
      begin
         funcSelect <= next_funcSelect;
         amtFwdToRev <= next_amtFwdToRev;
         amtRevToFwd <= next_amtRevToFwd;
         filterTc <= next_filterTc;
         startDelay <= next_startDelay;
         deadBand <= next_deadBand;
         regRdata <= next_regRdata;
      end
   end

   // direction tracking, delay timing, compensation and torque sum
   always_comb
   begin
      next_state = state;
      next_dirKnown = dirKnown;
      next_dirFwd = dirFwd;
      next_tickCnt = tick ? 16'h0000 : 16'(tickCnt + 16'h0001);
      next_delayCnt = delayCnt;
      next_hpfAcc = hpfAcc;
      next_comp = comp;
      if (droopValid && moving)
      begin
         next_dirKnown = 1'b1;
         next_dirFwd = !droopDelta[15];
      end
      case (state)
         lmc_pkg::LMC_DELAY:
         begin
            // (R06) wait out the start delay
            if (tick)
            begin
               next_delayCnt = 16'(delayCnt + 16'h0001);
               if (next_delayCnt >= startDelay)
               begin
                  next_state = lmc_pkg::LMC_APPLY;
                  // (R04) direction amount
                  next_comp = lmc_amount(dirFwd, amtFwdToRev, amtRevToFwd);
               end
            end
         end
         lmc_pkg::LMC_APPLY:
         begin
            // (R09) high-pass decay, 16 steps per filterTc ticks, at most one a tick
            if (filterTc != 16'h0000 && tick)
            begin
               if ({1'b0, hpfAcc} + 17'(lmc_pkg::HPF_STEPS) >= {1'b0, filterTc})
               begin
                  next_hpfAcc = (filterTc > 16'(lmc_pkg::HPF_STEPS))
                     ? 16'(hpfAcc + 16'(lmc_pkg::HPF_STEPS) - filterTc) : 16'h0000;
                  next_comp = comp - (comp >>> lmc_pkg::HPF_SHIFT);
               end
               else
                  next_hpfAcc = 16'(hpfAcc + 16'(lmc_pkg::HPF_STEPS));
            end
         end
         default:
         begin
            next_comp = 17'h0_0000;
         end
      endcase
      // (R05) restart on reversal
      if (reversal)
      begin
         next_delayCnt = 16'h0000;
         next_hpfAcc = 16'h0000;
         next_tickCnt = 16'h0000;
         if (startDelay == 16'h0000)
         begin
            next_state = lmc_pkg::LMC_APPLY;
            next_comp = lmc_amount(!droopDelta[15], amtFwdToRev, amtRevToFwd);
         end
         else
         begin
            next_state = lmc_pkg::LMC_DELAY;
            next_comp = 17'h0_0000;
         end
      end
      // (R01) (R02) off outside allowed modes or when disabled
      if (!enabled)
      begin
         next_state = lmc_pkg::LMC_IDLE;
         next_comp = 17'h0_0000;
      end
      // (R10) add compensation, saturated
      sum = 18'(torqueIn) + 18'(comp);
      if (sum > 18'sh0_7FFF)
         next_torqueOut = 16'sh7FFF;
      else if (sum < -18'sh0_8000)
         next_torqueOut = -16'sh8000;
      else
         next_torqueOut = sum[15:0];
      next_compActive = (state == lmc_pkg::LMC_APPLY);
   end

   // state registers, frozen while clkEn is low
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= lmc_pkg::LMC_IDLE;
         dirKnown <= 1'b0;
         dirFwd <= 1'b0;
         tickCnt <= 16'h0000;
         delayCnt <= 16'h0000;
         hpfAcc <= 16'h0000;
         comp <= 17'h0_0000;
         torqueOut <= 16'sh0000;
         compActive <= 1'b0;
      end
      else if (clkEn)
      begin
         state <= next_state;
         dirKnown <= next_dirKnown;
         dirFwd <= next_dirFwd;
         tickCnt <= next_tickCnt;
         delayCnt <= next_delayCnt;
         hpfAcc <= next_hpfAcc;
         comp <= next_comp;
         torqueOut <= next_torqueOut;
         compActive <= next_compActive;
      end
   end

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_mode_gate;
      (clkEn && !modeOk) |=> (comp == 17'h0_0000) && (state == lmc_pkg::LMC_IDLE);
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("comp outside mode"); // (R01)
   property p_enable_gate;
      (clkEn && !funcSelect[0]) |=> ##1 !compActive;
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("comp while off"); // (R02)
   property p_unit_kpulse;
      (clkEn && droopValid && funcSelect[1]
         && {9'h000, absDelta} <= 26'(deadBand * lmc_pkg::KPULSE_SCALE)) |-> !reversal;
   endproperty
   a_unit_kpulse: assert property (p_unit_kpulse) else $error("kpulse band"); // (R03)
   property p_amount_sel;
      (clkEn && enabled && reversal && startDelay == 16'h0000)
         |=> comp == (dirFwd ? $signed({1'b0, amtRevToFwd})
         : -$signed({1'b0, amtFwdToRev}));
   endproperty
   a_amount_sel: assert property (p_amount_sel) else $error("wrong amount"); // (R04)
   property p_reversal_starts;
      (enabled && reversal) |=> state != lmc_pkg::LMC_IDLE;
   endproperty
   a_reversal_starts: assert property (p_reversal_starts) else $error("no event"); // (R05)
   property p_delay_holds;
      (enabled && reversal && startDelay != 16'h0000)
         |=> (state == lmc_pkg::LMC_DELAY) && (comp == 17'h0_0000);
   endproperty
   a_delay_holds: assert property (p_delay_holds) else $error("early start"); // (R06)
   property p_delay_reset;
      $rose(rstn) |-> startDelay == lmc_pkg::RST_START_DELAY;
   endproperty
   a_delay_reset: assert property (p_delay_reset) else $error("delay not zero"); // (R07)
   property p_dead_band;
      (clkEn && droopValid && !funcSelect[1]
         && {9'h000, absDelta} <= {10'h000, deadBand}) |-> !reversal;
   endproperty
   a_dead_band: assert property (p_dead_band) else $error("band ignored"); // (R08)
   property p_no_filter_hold;
      (clkEn && state == lmc_pkg::LMC_APPLY && filterTc == 16'h0000
         && next_state == lmc_pkg::LMC_APPLY && !reversal) |=> $stable(comp);
   endproperty
   a_no_filter_hold: assert property (p_no_filter_hold) else $error("comp drifts"); // (R09)
   property p_torque_sum;
      (clkEn && comp == 17'h0_0000) |=> torqueOut == $past(torqueIn);
   endproperty
   a_torque_sum: assert property (p_torque_sum) else $error("torque altered"); // (R10)
endmodule : lmc_lost_motion_comp

// ---- bench/lmc_motion_source.sv ----
// lmc_motion_source: stands in for the position command source and torque loop
// assumes the bench sets the droop rate; samples leave on a fixed cadence
`timescale 1ns/10ps
module lmc_motion_source #(
   parameter int SAMPLE_GAP = 4,
   parameter logic signed [15:0] TORQUE_CMD = 16'h0064
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic signed [15:0] speed,
   output logic droopValid,
   output logic signed [15:0] droopDelta,
   output logic signed [15:0] torqueIn
);
   logic [3:0] gap;
   // one droop sample per gap; the delta line is scrambled between samples
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         gap <= 4'h0;
         droopValid <= 1'b0;
         droopDelta <= 16'h0000;
      end
      else
      begin
         gap <= (gap == 4'(SAMPLE_GAP - 1)) ? 4'h0 : gap + 4'h1;
         droopValid <= (gap == 4'h0);
         droopDelta <= (gap == 4'h0) ? speed : ~droopDelta;
      end
   end
   // torque loop command held steady
   assign torqueIn = TORQUE_CMD;
endmodule : lmc_motion_source

// ---- bench/lmc_lost_motion_comp_tb_top.sv ----
// lmc_lost_motion_comp_tb_top: self-checking bench for the compensation stage
// assumes a 200 MHz clock and a short time base of 4 cycles per tick
`timescale 1ns/10ps
module lmc_lost_motion_comp_tb_top;
   localparam int TICK = 4;
   localparam logic signed [15:0] TQ = 16'h0064;
   localparam logic [15:0] F2R = 16'h012C;
   localparam logic [15:0] R2F = 16'h00C8;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic clkEn = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWdata = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [15:0] regRdata;
   logic [1:0] ctrlMode = 2'h0;
   logic droopValid;
   logic signed [15:0] droopDelta;
   logic signed [15:0] torqueIn;
   logic signed [15:0] torqueOut;
   logic compActive;
   logic signed [15:0] speed = 16'h0000;
   int num_errors = 0;
   int n_tests = 0;
   // free running clock
   always #2.5 clock = ~clock;
   lmc_motion_source #(.SAMPLE_GAP(4), .TORQUE_CMD(TQ)) lmc_motion_source_i (
      .clock(clock), .rstn(rstn), .speed(speed), .droopValid(droopValid),
      .droopDelta(droopDelta), .torqueIn(torqueIn));
   lmc_lost_motion_comp #(.TICK_LEN(TICK)) lmc_lost_motion_comp_i (
      .clock(clock), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .ctrlMode(ctrlMode), .droopValid(droopValid), .droopDelta(droopDelta),
      .torqueIn(torqueIn), .torqueOut(torqueOut), .compActive(compActive));
   // comparison and counting
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t ns %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("errors %0d of %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // register port cycles
   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clock);
      regWr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : reg_read
   // move at a rate, settle, then compare the torque
   task automatic move(input logic signed [15:0] s, input int cyc, input logic [15:0] exp);
      @(posedge clock);
      speed <= s;
      repeat (cyc) @(posedge clock);
      #1 check(torqueOut, exp, "torque");
   endtask : move
   task automatic test_reset_values;
      logic [15:0] d;
      for (int i = 0; i < 6; i++)
      begin
         reg_read(8'(4 * i), d);
         check(d, 16'h0000, "reset value");
      end
      reg_read(8'h1C, d);
      check(d, 16'h0000, "unmapped read");
   endtask : test_reset_values
   task automatic test_disabled;
      reg_write(lmc_pkg::OFS_AMT_FWD_TO_REV, F2R);
      reg_write(lmc_pkg::OFS_AMT_REV_TO_FWD, R2F);
      reg_write(8'h1C, 16'hFFFF);
      move(16'h0014, 12, TQ);
      move(-16'sd20, 12, TQ);
      check({15'h0, compActive}, 16'h0000, "active while off");
   endtask : test_disabled
   task automatic test_reversal;
      logic [15:0] d;
      reg_write(lmc_pkg::OFS_FUNC_SELECT, 16'h0001);
      move(16'h0014, 12, TQ + R2F);
      move(-16'sd20, 12, TQ - F2R);
      reg_read(lmc_pkg::OFS_STATUS, d);
      check({14'h0, d[1:0]}, 16'h0003, "state apply");
   endtask : test_reversal
   task automatic test_modes;
      @(posedge clock);
      ctrlMode <= 2'h2;
      move(-16'sd20, 6, TQ);
      @(posedge clock);
      ctrlMode <= 2'h3;
      move(16'h0014, 12, TQ);
      @(posedge clock);
      ctrlMode <= 2'h1;
      move(-16'sd20, 12, TQ - F2R);
      // a frozen stage sees no reversal until enabled again
      @(posedge clock);
      clkEn <= 1'b0;
      move(16'h0014, 12, TQ - F2R);
      @(posedge clock);
      clkEn <= 1'b1;
      move(16'h0014, 12, TQ + R2F);
      move(-16'sd20, 12, TQ - F2R);
   endtask : test_modes
   task automatic test_dead_band;
      reg_write(lmc_pkg::OFS_DEAD_BAND, 16'h0005);
      move(16'h0005, 12, TQ - F2R);
      move(16'h0006, 12, TQ + R2F);
      reg_write(lmc_pkg::OFS_FUNC_SELECT, 16'h0003);
      reg_write(lmc_pkg::OFS_DEAD_BAND, 16'h0001);
      move(-16'sd1000, 12, TQ + R2F);
      move(-16'sd1001, 12, TQ - F2R);
   endtask : test_dead_band
   task automatic test_delay;
      reg_write(lmc_pkg::OFS_FUNC_SELECT, 16'h0001);
      reg_write(lmc_pkg::OFS_DEAD_BAND, 16'h0000);
      reg_write(lmc_pkg::OFS_START_DELAY, 16'h0002);
      // old amount drops at the reversal, new one waits two ticks
      move(16'h0014, 6, TQ);
      move(16'h0014, 14, TQ + R2F);
   endtask : test_delay
   task automatic test_filter;
      reg_write(lmc_pkg::OFS_START_DELAY, 16'h0000);
      reg_write(lmc_pkg::OFS_FILTER_TC, 16'h0001);
      // amount decays, part way after a few ticks, fully after many
      @(posedge clock);
      speed <= -16'sd20;
      repeat (40) @(posedge clock);
      #1 check({15'h0, (torqueOut > $signed(TQ - F2R)) && (torqueOut < TQ)}, 16'h0001, "decay");
      move(-16'sd20, 480, TQ);
   endtask : test_filter
   // main sequence
   initial
   begin
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      test_reset_values();
      test_disabled();
      test_reversal();
      test_modes();
      test_dead_band();
      test_delay();
      test_filter();
      report_and_stop();
   end
   // watchdog far beyond the expected run
   initial
   begin
      #20000;
      num_errors++;
      report_and_stop();
   end
endmodule : lmc_lost_motion_comp_tb_top
